// ==== common/lhap_defines.svh ====
// Constants of the line unit host access port
`ifndef LHAP_DEFINES_SVH
`define LHAP_DEFINES_SVH
// Device register offsets
`define LHAP_GLBCFG_OFS  8'h02
`define LHAP_MASK0_OFS   8'h14
`define LHAP_MASK1_OFS   8'h15
`define LHAP_STAT0_OFS   8'h19
`define LHAP_STAT1_OFS   8'h1A
// Device reset values
`define LHAP_GLBCFG_RST  8'h00
`define LHAP_MASK_RST    8'hFF
// Interrupt pin style field of global_config, bits [1:0]
`define LHAP_INT_OD_LOW  2'h0
`define LHAP_INT_PP_LOW  2'h1
`define LHAP_INT_PP_HIGH 2'h2
// Interface mode pin codes
`define LHAP_MODE_HW     2'h0
`define LHAP_MODE_SER    2'h1
`define LHAP_MODE_STB    2'h2
`define LHAP_MODE_ALE    2'h3
// Serial frame: bit count of command and of whole frame
`define LHAP_SER_CMD     5'h08
`define LHAP_SER_LAST    5'h10
// Host controller register byte addresses
`define LHAP_H_CMD       5'h00
`define LHAP_H_CFG       5'h04
`define LHAP_H_STAT      5'h08
`define LHAP_H_IRQ       5'h0C
`define LHAP_H_MASK      5'h10
`define LHAP_H_CFG_RST   4'h1
// Host timing counts in clk_sys cycles
`define LHAP_STB_CYC     8'h08
`define LHAP_SCLK_HALF   8'h08
`endif

// ==== common/lhap_pkg.sv ====
// Types of the line unit host access port
package lhap_pkg;
	// Device inputs as seen through the synchroniser
	typedef struct packed {
		logic       csN;
		logic       sclk;
		logic       serialIn;
		logic       outEdgePick;
		logic       latchEn;
		logic       addrStrobeN;
		logic       phaseStrobeN;
		logic       readN;
		logic       writeN;
		logic       dirRead;
		logic [1:0] ifMode;
		logic [7:0] ad;
	} lhap_dpins_t;

	typedef struct packed {
		lhap_dpins_t syn1;
		lhap_dpins_t syn2;
		lhap_dpins_t prv;
		logic [7:0]  addr;
		logic [7:0]  shIn;
		logic [7:0]  rdSh;
		logic [7:0]  glbCfg;
		logic [7:0]  mask0;
		logic [7:0]  mask1;
		logic [7:0]  stat0;
		logic [7:0]  stat1;
		logic [7:0]  adOut;
		logic [4:0]  bitCnt;
		logic        rdCmd;
		logic        sOut;
		logic        adOe;
		logic        ackN;
		logic        ready;
	} lhap_dev_st_t;

	// Host inputs as seen through the synchroniser
	typedef struct packed {
		logic       serialOut;
		logic       ackN;
		logic       ready;
		logic       intLine;
		logic [7:0] ad;
	} lhap_hpins_t;

	typedef enum logic [2:0] {
		HS_IDLE, HS_ADDR, HS_AGAP, HS_DSET, HS_DSTB, HS_DEND, HS_SER
	} lhap_hs_t;

	typedef struct packed {
		lhap_hpins_t syn1;
		lhap_hpins_t syn2;
		lhap_hs_t    st;
		logic [7:0]  cnt;
		logic [4:0]  riseCnt;
		logic        sclk;
		logic        csN;
		logic        sIn;
		logic        latchEn;
		logic        asN;
		logic        phaseStbN;
		logic        rdN;
		logic        wrN;
		logic        dirRd;
		logic        adOe;
		logic [7:0]  adOut;
		logic [15:0] tx;
		logic [7:0]  rx;
		logic [3:0]  cfg;
		logic [7:0]  cAddr;
		logic [7:0]  cData;
		logic        cRead;
		logic        intAct;
		logic [1:0]  irqSt;
		logic [1:0]  irqMask;
		logic        busAck;
		logic [31:0] rdata;
	} lhap_host_st_t;
endpackage : lhap_pkg

// ==== common/lhap_if.sv ====
// Pins between host and line unit access port
`timescale 1ns/1ns
interface lhap_if;
	logic       csN;
	logic       sclk;
	logic       outEdgePick;
	logic       serialIn;
	logic       serialOut;
	logic [1:0] ifMode;
	logic       latchEn;
	logic       addrStrobeN;
	logic       phaseStrobeN;
	logic       readN;
	logic       writeN;
	logic       dirRead;
	logic [7:0] adHost;
	logic       adHostOe;
	logic [7:0] adDev;
	logic       adDevOe;
	logic       ackN;
	logic       ready;
	logic       intPin;
	logic       intPinOe;
	logic [7:0] ad;
	logic       intLine;

	// Bus pulled to ground, interrupt line pulled up
	assign ad = adDevOe ? adDev : (adHostOe ? adHost : 8'h00);
	assign intLine = intPinOe ? intPin : 1'b1;

	modport dev (
		input  csN, sclk, outEdgePick, serialIn, ifMode, latchEn,
		       addrStrobeN, phaseStrobeN, readN, writeN, dirRead, ad,
		output serialOut, adDev, adDevOe, ackN, ready, intPin, intPinOe
	);
	modport host (
		input  serialOut, ad, ackN, ready, intLine,
		output csN, sclk, outEdgePick, serialIn, ifMode, latchEn,
		       addrStrobeN, phaseStrobeN, readN, writeN, dirRead,
		       adHost, adHostOe
	);
endinterface : lhap_if

// ==== hw/lhap_device.sv ====
// Device end: register access over serial or multiplexed parallel pins
// Operation
// R1 - Masked sources merged onto one interrupt pin
// R2 - Two readable interrupt status registers
// R3 - Config field picks interrupt pin drive style
// R4 - Serial input captured on shift clock rise
// R5 - Edge pick selects serial output launch edge
// R6 - Host samples serial output on opposite edge
// R7 - Address taken on latch enable falling edge
// R8 - Address taken on address strobe falling edge
// R9 - Write strobe low captures bus data
// R10 - Host: direction low write, high read
// R11 - Acknowledge low on read data or write accepted
// R12 - Ready low during access, high when done
// R13 - Chip select high blocks all accesses
// R14 - Read data driven while read strobe low
// R15 - Phase strobe frames data, direction picks way
// R16 - Interrupt follows any unmasked status bit
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`include "lhap_defines.svh"
module lhap_device
	import lhap_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Host pins
	lhap_if.dev              pins,
	// Line unit side
	input  wire logic [15:0] events,
	output logic      [7:0]  glbCfgOut
);
	lhap_dev_st_t s_r;
	lhap_dev_st_t s_nxt;
	lhap_dpins_t  pinsIn;

	// Register read decode, shared by serial and parallel paths
	function automatic logic [7:0] regRead(input logic [7:0] a,
		input lhap_dev_st_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`LHAP_GLBCFG_OFS: v = s.glbCfg;
			`LHAP_MASK0_OFS: v = s.mask0;
			`LHAP_MASK1_OFS: v = s.mask1;
			`LHAP_STAT0_OFS: v = s.stat0; // R2
			`LHAP_STAT1_OFS: v = s.stat1; // R2
			default:         v = 8'h00;
		endcase
		return v;
	endfunction : regRead

	// Gather pins for the synchroniser
	assign pinsIn = '{csN: pins.csN, sclk: pins.sclk,
		serialIn: pins.serialIn, outEdgePick: pins.outEdgePick,
		latchEn: pins.latchEn, addrStrobeN: pins.addrStrobeN,
		phaseStrobeN: pins.phaseStrobeN, readN: pins.readN,
		writeN: pins.writeN, dirRead: pins.dirRead,
		ifMode: pins.ifMode, ad: pins.ad};

	// Next state
	always_comb
	begin
		lhap_dpins_t p;
		lhap_dpins_t q;
		logic        sel;
		logic        rdEn;
		logic        wrEn;
		logic [7:0]  acAddr;
		logic [7:0]  wrData;
		logic [7:0]  v;
		logic [7:0]  cmd;
		logic        launch;
		p = s_r.syn2;
		q = s_r.prv;
		sel = 1'b0;
		rdEn = 1'b0;
		wrEn = 1'b0;
		acAddr = s_r.addr;
		wrData = 8'h00;
		v = 8'h00;
		cmd = 8'h00;
		launch = 1'b0;
		s_nxt = s_r;
		// Only syn2 reads syn1; edges come from syn2 against prv
		s_nxt.syn1 = pinsIn;
		s_nxt.syn2 = s_r.syn1;
		s_nxt.prv = s_r.syn2;
		sel = ~p.csN; // R13
		s_nxt.ready = 1'b1;
		unique case (p.ifMode)
			`LHAP_MODE_SER:
			begin
				s_nxt.ackN = 1'b1;
				s_nxt.adOe = 1'b0;
				if (!sel)
					s_nxt.bitCnt = 5'h00; // R13
				else if (p.sclk && !q.sclk &&
					s_r.bitCnt != `LHAP_SER_LAST)
				begin
					// Rising shift clock edge
					s_nxt.shIn = {s_r.shIn[6:0], p.serialIn}; // R4
					s_nxt.bitCnt = s_r.bitCnt + 5'h01;
					cmd = {s_r.shIn[6:0], p.serialIn};
					if (s_r.bitCnt == `LHAP_SER_CMD - 5'h01)
					begin
						s_nxt.rdCmd = cmd[7];
						s_nxt.addr = {1'b0, cmd[6:0]};
						if (cmd[7])
						begin
							rdEn = 1'b1;
							acAddr = {1'b0, cmd[6:0]};
							v = regRead(acAddr, s_r);
							s_nxt.rdSh = v;
							// Rising launch puts the first bit out now
							if (!p.outEdgePick)
							begin
								s_nxt.sOut = v[7]; // R5
								s_nxt.rdSh = {v[6:0], 1'b0};
							end
						end
					end
					else if (s_r.bitCnt == `LHAP_SER_LAST - 5'h01 &&
						!s_r.rdCmd)
					begin
						wrEn = 1'b1;
						wrData = cmd;
					end
					else if (s_r.rdCmd && !p.outEdgePick &&
						s_r.bitCnt >= `LHAP_SER_CMD)
						launch = 1'b1; // R5
				end
				else if (!p.sclk && q.sclk && s_r.rdCmd &&
					p.outEdgePick && s_r.bitCnt >= `LHAP_SER_CMD &&
					s_r.bitCnt < `LHAP_SER_LAST)
					launch = 1'b1; // R5
				// Bit stands a full half period for the host (R6)
				if (launch)
				begin
					s_nxt.sOut = s_r.rdSh[7];
					s_nxt.rdSh = {s_r.rdSh[6:0], 1'b0};
				end
			end
			`LHAP_MODE_ALE:
			begin
				s_nxt.ackN = 1'b1;
				// Drive only while read strobe stays low
				if (p.readN || !sel)
					s_nxt.adOe = 1'b0; // R14
				if (sel && q.latchEn && !p.latchEn)
					s_nxt.addr = p.ad; // R7
				if (sel && q.writeN && !p.writeN)
				begin
					s_nxt.ready = 1'b0; // R12
					wrEn = 1'b1; // R9
					wrData = p.ad;
				end
				else if (sel && q.readN && !p.readN)
				begin
					s_nxt.ready = 1'b0; // R12
					rdEn = 1'b1;
					s_nxt.adOut = regRead(s_r.addr, s_r);
					s_nxt.adOe = 1'b1; // R14
				end
			end
			`LHAP_MODE_STB:
			begin
				if (sel && q.addrStrobeN && !p.addrStrobeN)
					s_nxt.addr = p.ad; // R8
				// Strobe release ends the data phase
				if (p.phaseStrobeN || !sel)
				begin
					s_nxt.ackN = 1'b1;
					s_nxt.adOe = 1'b0; // R15
				end
				else if (q.phaseStrobeN)
				begin
					s_nxt.ackN = 1'b0; // R11
					if (p.dirRead)
					begin
						rdEn = 1'b1;
						s_nxt.adOut = regRead(s_r.addr, s_r);
						s_nxt.adOe = 1'b1; // R15
					end
					else
					begin
						wrEn = 1'b1; // R15
						wrData = p.ad;
					end
				end
			end
			default:
			begin
				// Hardware control: host port stays quiet
				s_nxt.ackN = 1'b1;
				s_nxt.adOe = 1'b0;
			end
		endcase
		// Writable registers; status is read only
		if (wrEn)
		begin
			unique case (acAddr)
				`LHAP_GLBCFG_OFS: s_nxt.glbCfg = wrData;
				`LHAP_MASK0_OFS: s_nxt.mask0 = wrData;
				`LHAP_MASK1_OFS: s_nxt.mask1 = wrData;
				default:         s_nxt.glbCfg = s_r.glbCfg;
			endcase
		end
		// Sticky status, read clears, a new event wins over the clear
		s_nxt.stat0 = s_r.stat0;
		s_nxt.stat1 = s_r.stat1;
		if (rdEn && acAddr == `LHAP_STAT0_OFS)
			s_nxt.stat0 = 8'h00;
		if (rdEn && acAddr == `LHAP_STAT1_OFS)
			s_nxt.stat1 = 8'h00;
		s_nxt.stat0 = s_nxt.stat0 | events[7:0]; // R2
		s_nxt.stat1 = s_nxt.stat1 | events[15:8]; // R2
	end

	// State register
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_r <= '0;
			s_r.syn1 <= '1;
			s_r.syn2 <= '1;
			s_r.prv <= '1;
			s_r.glbCfg <= `LHAP_GLBCFG_RST;
			s_r.mask0 <= `LHAP_MASK_RST;
			s_r.mask1 <= `LHAP_MASK_RST;
			s_r.ackN <= 1'b1;
			s_r.ready <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// Interrupt pin: mask bit high blocks its source
	logic intAct;
	assign intAct = |(s_r.stat0 & ~s_r.mask0) |
		|(s_r.stat1 & ~s_r.mask1); // R1 R16

	// Pin drive style from the config field
	always_comb
	begin
		unique case (s_r.glbCfg[1:0]) // R3
			`LHAP_INT_OD_LOW:
			begin
				pins.intPin = 1'b0;
				pins.intPinOe = intAct;
			end
			`LHAP_INT_PP_LOW:
			begin
				pins.intPin = ~intAct;
				pins.intPinOe = 1'b1;
			end
			default:
			begin
				pins.intPin = intAct;
				pins.intPinOe = 1'b1;
			end
		endcase
	end

	// Outputs straight from flops
	assign pins.serialOut = s_r.sOut;
	assign pins.adDev = s_r.adOut;
	assign pins.adDevOe = s_r.adOe;
	assign pins.ackN = s_r.ackN;
	assign pins.ready = s_r.ready;
	assign glbCfgOut = s_r.glbCfg;
endmodule : lhap_device

// ==== hw/lhap_host.sv ====
// Host end: Avalon-MM controlled master of the device access pins
`timescale 1ns/1ns
`include "lhap_defines.svh"
module lhap_host
	import lhap_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	// Device pins
	lhap_if.host             pins
);
	lhap_host_st_t s_r;
	lhap_host_st_t s_nxt;
	lhap_hpins_t   pinsIn;

	assign pinsIn = '{serialOut: pins.serialOut, ackN: pins.ackN,
		ready: pins.ready, intLine: pins.intLine, ad: pins.ad};

	// Next state
	always_comb
	begin
		lhap_hpins_t p;
		logic        req;
		logic        take;
		logic        tick;
		logic        done;
		logic        latchBus;
		logic        edgePick;
		logic        devInt;
		p = s_r.syn2;
		req = avs_read | avs_write;
		take = req & s_r.busAck;
		tick = s_r.cnt == `LHAP_STB_CYC;
		done = 1'b0;
		latchBus = s_r.cfg[1:0] == `LHAP_MODE_ALE;
		edgePick = s_r.cfg[2];
		s_nxt = s_r;
		s_nxt.syn1 = pinsIn;
		s_nxt.syn2 = s_r.syn1;
		s_nxt.cnt = s_r.cnt + 8'h01;
		s_nxt.busAck = req & ~s_r.busAck;
		// Read data loaded one cycle ahead so it stands at the take edge
		if (req && !s_r.busAck)
		begin
			unique case (avs_address)
				`LHAP_H_CFG:  s_nxt.rdata = {28'h0000000, s_r.cfg};
				`LHAP_H_STAT: s_nxt.rdata = {16'h0000, s_r.rx,
					7'h00, s_r.st != HS_IDLE};
				`LHAP_H_IRQ:  s_nxt.rdata = {30'h0000000, s_r.irqSt};
				`LHAP_H_MASK: s_nxt.rdata = {30'h0000000, s_r.irqMask};
				default:      s_nxt.rdata = 32'h00000000;
			endcase
		end
		if (take && avs_write)
		begin
			unique case (avs_address)
				`LHAP_H_CFG:  s_nxt.cfg = avs_writedata[3:0];
				`LHAP_H_MASK: s_nxt.irqMask = avs_writedata[1:0];
				default:      s_nxt.cfg = s_r.cfg;
			endcase
		end
		// Start only from idle; a command while busy is dropped
		if (take && avs_write && avs_address == `LHAP_H_CMD &&
			s_r.st == HS_IDLE)
		begin
			s_nxt.cData = avs_writedata[7:0];
			s_nxt.cAddr = avs_writedata[15:8];
			s_nxt.cRead = avs_writedata[16];
		end
		unique case (s_r.st)
			HS_IDLE:
			begin
				if (take && avs_write && avs_address == `LHAP_H_CMD &&
					s_r.cfg[1:0] != `LHAP_MODE_HW)
				begin
					s_nxt.csN = 1'b0; // R13
					s_nxt.cnt = 8'h00;
					s_nxt.dirRd = avs_writedata[16]; // R10
					if (s_r.cfg[1:0] == `LHAP_MODE_SER)
					begin
						s_nxt.tx = {avs_writedata[16],
							avs_writedata[14:8], avs_writedata[7:0]};
						s_nxt.sIn = avs_writedata[16];
						s_nxt.riseCnt = 5'h00;
						s_nxt.st = HS_SER;
					end
					else
					begin
						s_nxt.adOut = avs_writedata[15:8];
						s_nxt.adOe = 1'b1;
						s_nxt.latchEn = latchBus;
						s_nxt.asN = latchBus;
						s_nxt.st = HS_ADDR;
					end
				end
			end
			HS_ADDR:
				if (tick)
				begin
					// Falling latch enable takes the address (R7)
					s_nxt.latchEn = 1'b0;
					s_nxt.asN = 1'b1;
					s_nxt.cnt = 8'h00;
					s_nxt.st = HS_AGAP;
				end
			HS_AGAP:
				if (tick)
				begin
					s_nxt.adOe = ~s_r.cRead;
					s_nxt.adOut = s_r.cData;
					s_nxt.cnt = 8'h00;
					s_nxt.st = HS_DSET;
				end
			HS_DSET:
				if (tick)
				begin
					s_nxt.rdN = ~(latchBus & s_r.cRead);
					s_nxt.wrN = ~(latchBus & ~s_r.cRead); // R9
					s_nxt.phaseStbN = latchBus; // R15
					s_nxt.cnt = 8'h00;
					s_nxt.st = HS_DSTB;
				end
			HS_DSTB:
				if ((latchBus && tick) || (!latchBus && !p.ackN))
				begin
					if (s_r.cRead)
						s_nxt.rx = p.ad;
					s_nxt.rdN = 1'b1;
					s_nxt.wrN = 1'b1;
					s_nxt.phaseStbN = 1'b1;
					s_nxt.cnt = 8'h00;
					s_nxt.st = HS_DEND;
				end
			HS_DEND:
			begin
				if (!(latchBus ? p.ready : p.ackN))
					s_nxt.cnt = 8'h00;
				else if (tick)
				begin
					s_nxt.csN = 1'b1;
					s_nxt.adOe = 1'b0;
					done = 1'b1;
					s_nxt.st = HS_IDLE;
				end
			end
			HS_SER:
			begin
				if (s_r.cnt == `LHAP_SCLK_HALF - 8'h01)
				begin
					s_nxt.cnt = 8'h00;
					if (!s_r.sclk)
					begin
						s_nxt.sclk = 1'b1;
						s_nxt.riseCnt = s_r.riseCnt + 5'h01;
						// Device launches on fall: take on rise
						if (edgePick && s_r.riseCnt >= `LHAP_SER_CMD)
							s_nxt.rx = {s_r.rx[6:0], p.serialOut}; // R6
					end
					else
					begin
						s_nxt.sclk = 1'b0;
						// Device launches on rise: take on fall
						if (!edgePick && s_r.riseCnt >= `LHAP_SER_CMD &&
							s_r.riseCnt < `LHAP_SER_LAST)
							s_nxt.rx = {s_r.rx[6:0], p.serialOut}; // R6
						if (s_r.riseCnt == `LHAP_SER_LAST)
						begin
							s_nxt.csN = 1'b1;
							done = 1'b1;
							s_nxt.st = HS_IDLE;
						end
						else
						begin
							s_nxt.tx = {s_r.tx[14:0], 1'b0};
							s_nxt.sIn = s_r.tx[14];
						end
					end
				end
			end
			default:
				s_nxt.st = HS_IDLE;
		endcase
		// Device interrupt level per configured polarity, edge sets
		devInt = s_r.cfg[3] ? p.intLine : ~p.intLine;
		s_nxt.intAct = devInt;
		if (take && avs_read && avs_address == `LHAP_H_IRQ)
			s_nxt.irqSt = 2'h0;
		s_nxt.irqSt = s_nxt.irqSt | {devInt & ~s_r.intAct, done};
	end

	// State register
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_r <= '0;
			s_r.syn1 <= '1;
			s_r.syn2 <= '1;
			s_r.st <= HS_IDLE;
			s_r.csN <= 1'b1;
			s_r.asN <= 1'b1;
			s_r.phaseStbN <= 1'b1;
			s_r.rdN <= 1'b1;
			s_r.wrN <= 1'b1;
			s_r.cfg <= `LHAP_H_CFG_RST;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs
	assign avs_waitrequest = (avs_read | avs_write) & ~s_r.busAck;
	assign avs_readdata = s_r.rdata;
	assign irq = |(s_r.irqSt & s_r.irqMask);
	assign pins.csN = s_r.csN;
	assign pins.sclk = s_r.sclk;
	assign pins.outEdgePick = s_r.cfg[2];
	assign pins.serialIn = s_r.sIn;
	assign pins.ifMode = s_r.cfg[1:0];
	assign pins.latchEn = s_r.latchEn;
	assign pins.addrStrobeN = s_r.asN;
	assign pins.phaseStrobeN = s_r.phaseStbN;
	assign pins.readN = s_r.rdN;
	assign pins.writeN = s_r.wrN;
	assign pins.dirRead = s_r.dirRd;
	assign pins.adHost = s_r.adOut;
	assign pins.adHostOe = s_r.adOe;
endmodule : lhap_host

// ==== dv/lhap_checker.sv ====
// Pin level assertions between host end and device end
`timescale 1ns/1ns
`include "lhap_defines.svh"
module lhap_checker
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       arst_n,
	// Interface pins
	input wire logic       csN,
	input wire logic       sclk,
	input wire logic       outEdgePick,
	input wire logic       serialOut,
	input wire logic [1:0] ifMode,
	input wire logic       phaseStrobeN,
	input wire logic       readN,
	input wire logic       writeN,
	input wire logic       dirRead,
	input wire logic       adHostOe,
	input wire logic       adDevOe,
	input wire logic       ackN,
	input wire logic       ready
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// Strobe bus handshake, allowing for two synchroniser stages
	AST_ACK_IN_PHASE: assert property (
		$fell(ackN) |-> ifMode == `LHAP_MODE_STB && !phaseStrobeN)
		else $error("Acknowledge outside a data phase");
	AST_ACK_TIMING: assert property (
		$fell(phaseStrobeN) && ifMode == `LHAP_MODE_STB && !csN
		|-> ##[2:6] !ackN)
		else $error("Acknowledge late after data strobe");
	AST_ACK_READ_DATA: assert property (
		$fell(ackN) && dirRead |-> adDevOe)
		else $error("Read acknowledged without bus drive");
	// Latch enable bus: ready pulse and read drive window
	AST_RDY_PULSE: assert property (
		$fell(ready) |=> ready)
		else $error("Ready low for more than one cycle");
	AST_RDY_TIMING: assert property (
		$fell(writeN) && ifMode == `LHAP_MODE_ALE && !csN
		|-> ##[2:6] $fell(ready))
		else $error("No ready pulse after write strobe");
	AST_RD_DRIVE: assert property (
		$fell(readN) && ifMode == `LHAP_MODE_ALE && !csN
		|-> ##[2:6] adDevOe)
		else $error("Read data not driven");
	AST_RD_RELEASE: assert property (
		(ifMode == `LHAP_MODE_ALE && readN) [*6] |-> !adDevOe)
		else $error("Bus held after read strobe");
	// Serial output moves only in the half after its launch edge
	AST_SOUT_EDGE: assert property (
		$changed(serialOut) && !csN && ifMode == `LHAP_MODE_SER
		|-> sclk == !outEdgePick)
		else $error("Serial output moved on the wrong edge");
	// Deselected device keeps acknowledge, ready and bus drive idle
	AST_CS_QUIET: assert property (
		csN [*8] |-> ackN && ready && !adDevOe)
		else $error("Device active while deselected");
	AST_BUS_ONE: assert property (
		!(adDevOe && adHostOe))
		else $error("Both ends drive the bus");
endmodule : lhap_checker

// ==== dv/tb_top.sv ====
// Bench joining host end and device end through the pin interface
`timescale 1ns/1ns
`include "lhap_defines.svh"
module tb_top;
	logic        clk_sys;
	logic        arst_n;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic [15:0] events;
	logic [7:0]  glbCfgOut;
	logic [3:0]  cfgCur;
	int          n_mismatch;
	int          checked;

	// Ends facing each other, checker beside the pins
	lhap_if lhap_if_inst ();
	lhap_device lhap_device_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.pins(lhap_if_inst), .events(events), .glbCfgOut(glbCfgOut));
	lhap_host lhap_host_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq), .pins(lhap_if_inst));
	lhap_checker lhap_checker_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.csN(lhap_if_inst.csN), .sclk(lhap_if_inst.sclk),
		.outEdgePick(lhap_if_inst.outEdgePick),
		.serialOut(lhap_if_inst.serialOut), .ifMode(lhap_if_inst.ifMode),
		.phaseStrobeN(lhap_if_inst.phaseStrobeN),
		.readN(lhap_if_inst.readN), .writeN(lhap_if_inst.writeN),
		.dirRead(lhap_if_inst.dirRead), .adHostOe(lhap_if_inst.adHostOe),
		.adDevOe(lhap_if_inst.adDevOe), .ackN(lhap_if_inst.ackN),
		.ready(lhap_if_inst.ready));

	// Clock at 10 MHz
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_bit

	// Request held until waitrequest is seen low at an edge
	task automatic av_xfer(input logic wr, input logic [4:0] adr,
		input logic [31:0] dat, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address   <= adr;
		avs_writedata <= dat;
		avs_write     <= wr;
		avs_read      <= !wr;
		// No cycle limit: only the watchdog ends a hung wait
		do
		begin
			@(posedge clk_sys);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : av_xfer

	// One device access; mode settles through the synchroniser first
	task automatic dev_acc(input logic rd, input logic [7:0] adr,
		input logic [7:0] dat, output logic [7:0] q);
		logic [31:0] v;
		av_xfer(1'b1, `LHAP_H_CFG, {28'h0000000, cfgCur}, v);
		repeat (6) @(posedge clk_sys);
		av_xfer(1'b1, `LHAP_H_CMD, {15'h000, rd, adr, dat}, v);
		do
		begin
			av_xfer(1'b0, `LHAP_H_STAT, 32'h00000000, v);
		end
		while (v[0] !== 1'b0);
		q = v[15:8];
	endtask : dev_acc

	task automatic dev_wr(input logic [7:0] adr, input logic [7:0] dat);
		logic [7:0] q;
		dev_acc(1'b0, adr, dat, q);
	endtask : dev_wr

	task automatic dev_chk(input logic [7:0] adr, input logic [7:0] exp);
		logic [7:0] q;
		dev_acc(1'b1, adr, 8'h00, q);
		cmp_val({24'h000000, q}, {24'h000000, exp});
	endtask : dev_chk

	task automatic pulse_ev(input logic [15:0] e);
		@(posedge clk_sys);
		events <= e;
		@(posedge clk_sys);
		events <= 16'h0000;
		repeat (4) @(posedge clk_sys);
	endtask : pulse_ev

	task automatic t_reset_vals();
		logic [31:0] v;
		av_xfer(1'b0, `LHAP_H_CFG, 32'h00000000, v);
		cmp_val(v, {28'h0000000, `LHAP_H_CFG_RST});
		// Unmapped host address reads zero
		av_xfer(1'b0, 5'h14, 32'h00000000, v);
		cmp_val(v, 32'h00000000);
		cfgCur = 4'h1;
		dev_chk(`LHAP_GLBCFG_OFS, `LHAP_GLBCFG_RST);
		dev_chk(`LHAP_MASK0_OFS, `LHAP_MASK_RST);
		dev_chk(`LHAP_MASK1_OFS, `LHAP_MASK_RST);
		dev_chk(`LHAP_STAT0_OFS, 8'h00);
		$display("Test reset_vals done");
	endtask : t_reset_vals

	// Serial both edges, strobe bus, latch bus; last pattern restores mask
	task automatic t_modes();
		logic [3:0] cfgs [4] = '{4'h1, 4'h5, 4'h2, 4'h3};
		logic [7:0] pat [4] = '{8'h5A, 8'hC3, 8'h96, 8'hFF};
		for (int i = 0; i < 4; i++)
		begin
			cfgCur = cfgs[i];
			dev_wr(`LHAP_MASK1_OFS, pat[i]);
			dev_chk(`LHAP_MASK1_OFS, pat[i]);
			dev_wr(`LHAP_STAT1_OFS, 8'hFF);
			dev_chk(`LHAP_STAT1_OFS, 8'h00);
			dev_chk(8'h30, 8'h00);
		end
		$display("Test modes done");
	endtask : t_modes

	// Each pin style, then a masked source
	task automatic t_irq();
		cfgCur = 4'h1;
		dev_wr(`LHAP_MASK0_OFS, 8'hFE);
		for (int s = 0; s < 3; s++)
		begin
			cfgCur = (s == 2) ? 4'h9 : 4'h1;
			dev_wr(`LHAP_GLBCFG_OFS, 8'(s));
			repeat (6) @(posedge clk_sys);
			cmp_val({24'h000000, glbCfgOut}, 32'(s));
			cmp_bit(lhap_if_inst.intPinOe, s != 0);
			cmp_bit(lhap_if_inst.intLine, s != 2);
			pulse_ev(16'h0001);
			cmp_bit(lhap_if_inst.intLine, s == 2);
			cmp_bit(lhap_if_inst.intPinOe, 1'b1);
			dev_chk(`LHAP_STAT0_OFS, 8'h01);
			repeat (4) @(posedge clk_sys);
			cmp_bit(lhap_if_inst.intLine, s != 2);
		end
		pulse_ev(16'h0200);
		cmp_bit(lhap_if_inst.intLine, 1'b0);
		dev_chk(`LHAP_STAT1_OFS, 8'h02);
		cmp_bit(lhap_if_inst.intLine, 1'b0);
		$display("Test irq done");
	endtask : t_irq

	// Host done event: clear, raise, clear again
	task automatic t_host_irq();
		logic [31:0] v;
		av_xfer(1'b1, `LHAP_H_MASK, 32'h00000001, v);
		av_xfer(1'b0, `LHAP_H_IRQ, 32'h00000000, v);
		@(posedge clk_sys);
		cmp_bit(irq, 1'b0);
		cfgCur = 4'h1;
		dev_wr(`LHAP_MASK0_OFS, 8'hFF);
		cmp_bit(irq, 1'b1);
		av_xfer(1'b0, `LHAP_H_IRQ, 32'h00000000, v);
		cmp_val(v, 32'h00000003);
		@(posedge clk_sys);
		cmp_bit(irq, 1'b0);
		// Mode 0 keeps the port idle, so a command there is dropped
		av_xfer(1'b1, `LHAP_H_CFG, 32'h00000000, v);
		av_xfer(1'b1, `LHAP_H_CMD, 32'h00010000, v);
		av_xfer(1'b0, `LHAP_H_STAT, 32'h00000000, v);
		cmp_val(v & 32'h00000001, 32'h00000000);
		cmp_bit(irq, 1'b0);
		cmp_bit(lhap_if_inst.csN, 1'b1);
		av_xfer(1'b0, `LHAP_H_MASK, 32'h00000000, v);
		cmp_val(v, 32'h00000001);
		$display("Test host_irq done");
	endtask : t_host_irq

	// Reset again in mid run: both ends return to reset values
	task automatic t_mid_reset();
		logic [31:0] v;
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		cmp_val({24'h000000, glbCfgOut}, 32'(`LHAP_GLBCFG_RST));
		cmp_bit(irq, 1'b0);
		av_xfer(1'b0, `LHAP_H_CFG, 32'h00000000, v);
		cmp_val(v, {28'h0000000, `LHAP_H_CFG_RST});
		av_xfer(1'b0, `LHAP_H_MASK, 32'h00000000, v);
		cmp_val(v, 32'h00000000);
		cfgCur = 4'h1;
		dev_chk(`LHAP_GLBCFG_OFS, `LHAP_GLBCFG_RST);
		$display("Test mid_reset done");
	endtask : t_mid_reset

	task end_sim();
		$display("Comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
		begin
			$display("TB: PASS");
		end
		else
		begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	// Watchdog sized well above the expected run
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_mismatch++;
		$display("Watchdog expired");
		end_sim();
	end

	// Main sequence
	initial
	begin
		n_mismatch    = 0;
		checked       = 0;
		arst_n        = 1'b0;
		avs_address   = 5'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h00000000;
		events        = 16'h0000;
		cfgCur        = 4'h1;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset_vals();
		t_modes();
		t_irq();
		t_host_irq();
		t_mid_reset();
		end_sim();
	end
endmodule : tb_top
